// ### design/irms_pkg.sv
// Purpose: Shared constants and types for the infrared motion sensor register block.
// Assumes: One 50 MHz clock; the serial bus pins are already synchronous to it.
// Notes: Register indices, field positions, reset values and timing counts live here.
package irms_pkg;

  // Clock rate and the automatic interrupt release time.
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned IRQ_HOLD_NS = 10_000_000;
  localparam int unsigned IRQ_HOLD_CYC = IRQ_HOLD_NS / CLK_PERIOD_NS;

  // Serial bus slave address and byte framing.
  localparam logic [6:0] SLAVE_ADDR = 7'h55;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;

  // Register indices.
  localparam logic [7:0] IDX_MOTION_STATUS = 8'h00;
  localparam logic [7:0] IDX_SHUTDOWN_CONTROL = 8'h01;
  localparam logic [7:0] IDX_SENSE_CONFIGURATION = 8'h11;

  // Reset values; the status register has no defined reset value, zero is used.
  localparam logic [7:0] SHUTDOWN_CONTROL_RST = 8'h00;
  localparam logic [7:0] SENSE_CONFIGURATION_RST = 8'h00;
  localparam logic [1:0] STATUS_FIELD_RST = 2'h0;

  // Field positions.
  localparam int unsigned STAT_PROX_LSB = 2;
  localparam int unsigned STAT_MOTION_LSB = 0;
  localparam int unsigned SHDN_SOFT_BIT = 0;
  localparam int unsigned CFG_MODE_BIT = 0;
  localparam int unsigned CFG_EC_LSB = 1;

  // Field codes.
  localparam logic MODE_MOTION = 1'b0;
  localparam logic MODE_PROXIMITY = 1'b1;
  localparam logic [1:0] PROX_AWAY = 2'h1;
  localparam logic [1:0] PROX_CLOSE = 2'h2;
  localparam logic [1:0] MOTION_B_TO_A = 2'h1;
  localparam logic [1:0] MOTION_A_TO_B = 2'h2;

  // Emitter duty: one pulse cycle in 512 when stable, one in 8 in active motion.
  localparam int unsigned DUTY_CNT_W = 9;
  localparam logic [8:0] DUTY_MASK_STABLE = 9'h1ff;
  localparam logic [8:0] DUTY_MASK_MOTION = 9'h007;

  // Serial bus slave phases.
  typedef enum logic [3:0] {
    IRMS_IDLE, IRMS_ADDR, IRMS_ADDR_ACK, IRMS_INDEX, IRMS_INDEX_ACK,
    IRMS_WDATA, IRMS_WDATA_ACK, IRMS_RDATA, IRMS_RD_ACK
  } irms_phase_t;

endpackage

// ### design/irms_regs.sv
// Purpose: Register file, serial bus slave, status reporting, interrupt and emitter duty.
// Assumes: scl_in and sda_in are synchronous to ref_clk and slow against it.
// Notes: The optical front end is outside; it hands in decoded codes on a strobe.
`timescale 1ns/10ps

// Operation
// RULE1: Read is address-write, index byte, repeated start, address-read, then data returned.
// RULE2: Indices 00h status, 01h shutdown, 11h configuration are decoded.
// RULE3: Status bits 3:2 hold proximity_state, bits 1:0 motion_direction, upper bits undefined.
// RULE4: proximity_state 01 means moving away, 10 approaching, others no motion.
// RULE5: motion_direction 01 means b toward a, 10 a toward b, others none.
// RULE6: Each field only updates in its own operating mode.
// RULE7: Configuration bit 0 selects motion (0) or proximity (1); resets to 0.
// RULE8: Configuration bits 3:1 choose emitter current 400/280/210/70 mA; reset 000.
// RULE9: Shutdown bit 0 low means software shutdown; resets low, so start shut down.
// RULE10: Shutdown of either kind keeps all register contents.
// RULE11: hw_shutdown_n low forces hardware shutdown until it returns high.
// RULE12: irq_n goes low when either status field changes from detected movement.
// RULE13: The host reads status after an interrupt; that read releases irq_n.
// RULE14: irq_n low for 10ms without a status read is released automatically.
// RULE15: Emitter averages 1/512 when stable or in proximity, 1/8 in active motion.
// RULE16: Slave address is 1010101 followed by direction bit, 0 write, 1 read.
// RULE17: Write is address, index, one data byte, MSB first, each acknowledged.
// RULE18: Writes to status or unmapped indices change nothing.
module irms_regs
  import irms_pkg::*;
#(
  parameter int unsigned IRQ_HOLD_CYCLES = IRQ_HOLD_CYC
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Serial bus; SDA is open drain, driven low while sda_oe is high.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Hardware shutdown pin.
  input wire logic hw_shutdown_n,
  // Decoded results from the optical front end.
  input wire logic det_valid,
  input wire logic [1:0] det_prox_code,
  input wire logic [1:0] det_motion_code,
  input wire logic motion_active,
  // Interrupt and emitter control.
  output logic irq_n,
  output logic emitter_pulse,
  output logic [2:0] emitter_current_sel,
  output logic op_mode,
  output logic shutdown_active
);

  // Complete state of the block.
  typedef struct packed {
    irms_phase_t phase;
    logic scl_prev;
    logic sda_prev;
    logic [3:0] bit_cnt;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic rw;
    logic [7:0] index;
    logic sda_oe;
    logic sda_o;
    logic [7:0] shutdown_control;
    logic [7:0] sense_configuration;
    logic [1:0] proximity_state;
    logic [1:0] motion_direction;
    logic irq_n;
    logic [31:0] irq_cnt;
    logic [DUTY_CNT_W-1:0] duty_cnt;
    logic emitter_pulse;
    logic shutdown_active;
  } irms_state_t;

  irms_state_t st_r;
  irms_state_t st_nxt;

  // Register read mux; writable registers read back as their stored value.
  function automatic logic [7:0] irms_read(input irms_state_t s, input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      IDX_MOTION_STATUS: begin
        v[STAT_PROX_LSB +: 2] = s.proximity_state; // RULE3
        v[STAT_MOTION_LSB +: 2] = s.motion_direction; // RULE3
      end
      IDX_SHUTDOWN_CONTROL: v = s.shutdown_control;
      IDX_SENSE_CONFIGURATION: v = s.sense_configuration;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Bus condition decode from the previous and present pin samples.
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic byte_done;
  logic operating;
  logic cur_mode;
  logic status_read;
  logic det_event;

  assign scl_rise = scl_in & ~st_r.scl_prev;
  assign scl_fall = ~scl_in & st_r.scl_prev;
  assign bus_start = scl_in & st_r.scl_prev & st_r.sda_prev & ~sda_in;
  assign bus_stop = scl_in & st_r.scl_prev & ~st_r.sda_prev & sda_in;
  assign byte_done = scl_fall & (st_r.bit_cnt == BITS_PER_BYTE);
  // Either shutdown halts sensing but leaves the registers alone.
  assign operating = hw_shutdown_n & st_r.shutdown_control[SHDN_SOFT_BIT]; // RULE9 RULE11
  assign cur_mode = st_r.sense_configuration[CFG_MODE_BIT]; // RULE7

  // Next-state logic for the whole block.
  always_comb begin
    st_nxt = st_r;
    status_read = 1'b0;
    det_event = 1'b0;
    st_nxt.scl_prev = scl_in;
    st_nxt.sda_prev = sda_in;
    st_nxt.sda_o = 1'b0;

    // Serial bus slave; a start or stop wins over any phase.
    if (bus_start) begin
      st_nxt.phase = IRMS_ADDR; // RULE1
      st_nxt.bit_cnt = 4'h0;
      st_nxt.sda_oe = 1'b0;
    end else if (bus_stop) begin
      st_nxt.phase = IRMS_IDLE;
      st_nxt.sda_oe = 1'b0;
    end else begin
      case (st_r.phase)
        IRMS_IDLE: begin
          st_nxt.sda_oe = 1'b0;
        end
        IRMS_ADDR: begin
          if (scl_rise) begin
            st_nxt.rx_shift = {st_r.rx_shift[6:0], sda_in};
            st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
          end else if (byte_done) begin
            if (st_r.rx_shift[7:1] == SLAVE_ADDR) begin
              st_nxt.rw = st_r.rx_shift[0]; // RULE16
              st_nxt.sda_oe = 1'b1;
              st_nxt.phase = IRMS_ADDR_ACK;
            end else begin
              st_nxt.phase = IRMS_IDLE; // RULE16
            end
          end
        end
        IRMS_ADDR_ACK: begin
          if (scl_fall) begin
            st_nxt.bit_cnt = 4'h0;
            if (st_r.rw == DIR_READ) begin
              // The index from the earlier write phase picks the register.
              st_nxt.tx_shift = irms_read(st_r, st_r.index); // RULE1
              st_nxt.sda_oe = ~st_nxt.tx_shift[7];
              st_nxt.phase = IRMS_RDATA;
              status_read = (st_r.index == IDX_MOTION_STATUS); // RULE13
            end else begin
              st_nxt.sda_oe = 1'b0;
              st_nxt.phase = IRMS_INDEX;
            end
          end
        end
        IRMS_INDEX: begin
          if (scl_rise) begin
            st_nxt.rx_shift = {st_r.rx_shift[6:0], sda_in};
            st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
          end else if (byte_done) begin
            st_nxt.index = st_r.rx_shift; // RULE17
            st_nxt.sda_oe = 1'b1;
            st_nxt.phase = IRMS_INDEX_ACK;
          end
        end
        IRMS_INDEX_ACK: begin
          if (scl_fall) begin
            st_nxt.bit_cnt = 4'h0;
            st_nxt.sda_oe = 1'b0;
            st_nxt.phase = IRMS_WDATA;
          end
        end
        IRMS_WDATA: begin
          if (scl_rise) begin
            st_nxt.rx_shift = {st_r.rx_shift[6:0], sda_in};
            st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
          end else if (byte_done) begin
            // Only the two writable registers take data; anything else is dropped.
            case (st_r.index) // RULE2 RULE18
              IDX_SHUTDOWN_CONTROL: st_nxt.shutdown_control = st_r.rx_shift;
              IDX_SENSE_CONFIGURATION: st_nxt.sense_configuration = st_r.rx_shift;
              default: st_nxt.index = st_r.index;
            endcase
            st_nxt.sda_oe = 1'b1; // RULE17
            st_nxt.phase = IRMS_WDATA_ACK;
          end
        end
        IRMS_WDATA_ACK: begin
          // One data byte per write; further bytes go unacknowledged.
          if (scl_fall) begin
            st_nxt.sda_oe = 1'b0;
            st_nxt.phase = IRMS_IDLE;
          end
        end
        IRMS_RDATA: begin
          if (scl_rise) begin
            st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
          end else if (byte_done) begin
            st_nxt.sda_oe = 1'b0;
            st_nxt.phase = IRMS_RD_ACK;
          end else if (scl_fall) begin
            st_nxt.tx_shift = {st_r.tx_shift[6:0], 1'b0};
            st_nxt.sda_oe = ~st_r.tx_shift[6];
          end
        end
        IRMS_RD_ACK: begin
          // A master acknowledge repeats the same register; a nack ends the read.
          if (scl_rise) begin
            st_nxt.phase = sda_in ? IRMS_IDLE : IRMS_ADDR_ACK;
          end
        end
        default: begin
          st_nxt.phase = IRMS_IDLE;
          st_nxt.sda_oe = 1'b0;
        end
      endcase
    end

    // Status update: each field follows only its own mode, and only while operating.
    if (det_valid && operating) begin
      if (cur_mode == MODE_MOTION && det_motion_code != st_r.motion_direction) begin
        st_nxt.motion_direction = det_motion_code; // RULE5 RULE6
        det_event = 1'b1;
      end
      if (cur_mode == MODE_PROXIMITY && det_prox_code != st_r.proximity_state) begin
        st_nxt.proximity_state = det_prox_code; // RULE4 RULE6
        det_event = 1'b1;
      end
    end

    // Interrupt: a new event wins over a status read in the same cycle.
    if (det_event) begin
      st_nxt.irq_n = 1'b0; // RULE12
      st_nxt.irq_cnt = 32'h0;
    end else if (!st_r.irq_n) begin
      if (status_read) begin
        st_nxt.irq_n = 1'b1; // RULE13
        st_nxt.irq_cnt = 32'h0;
      end else if (st_r.irq_cnt >= IRQ_HOLD_CYCLES - 1) begin
        st_nxt.irq_n = 1'b1; // RULE14
        st_nxt.irq_cnt = 32'h0;
      end else begin
        st_nxt.irq_cnt = st_r.irq_cnt + 32'h1; // RULE14
      end
    end

    // Emitter duty: a free counter gives one pulse per 512 or per 8 cycles of
    // the sensing slot, which keeps the average current at the required ratio.
    if (operating) begin
      st_nxt.duty_cnt = st_r.duty_cnt + 9'h001;
      if (cur_mode == MODE_MOTION && motion_active) begin
        st_nxt.emitter_pulse = ((st_r.duty_cnt & DUTY_MASK_MOTION) == 9'h000); // RULE15
      end else begin
        st_nxt.emitter_pulse = ((st_r.duty_cnt & DUTY_MASK_STABLE) == 9'h000); // RULE15
      end
    end else begin
      st_nxt.duty_cnt = 9'h000;
      st_nxt.emitter_pulse = 1'b0; // RULE10
    end
    st_nxt.shutdown_active = ~operating; // RULE11
  end

  // Single state register; reset loads constants only.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.phase <= IRMS_IDLE;
      st_r.scl_prev <= 1'b1;
      st_r.sda_prev <= 1'b1;
      st_r.bit_cnt <= 4'h0;
      st_r.rx_shift <= 8'h00;
      st_r.tx_shift <= 8'h00;
      st_r.rw <= DIR_WRITE;
      st_r.index <= IDX_MOTION_STATUS;
      st_r.sda_oe <= 1'b0;
      st_r.sda_o <= 1'b0;
      st_r.shutdown_control <= SHUTDOWN_CONTROL_RST; // RULE9
      st_r.sense_configuration <= SENSE_CONFIGURATION_RST; // RULE7 RULE8
      st_r.proximity_state <= STATUS_FIELD_RST;
      st_r.motion_direction <= STATUS_FIELD_RST;
      st_r.irq_n <= 1'b1;
      st_r.irq_cnt <= 32'h0;
      st_r.duty_cnt <= 9'h000;
      st_r.emitter_pulse <= 1'b0;
      st_r.shutdown_active <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign sda_out = st_r.sda_o;
  assign sda_oe = st_r.sda_oe;
  assign irq_n = st_r.irq_n;
  assign emitter_pulse = st_r.emitter_pulse;
  assign emitter_current_sel = st_r.sense_configuration[CFG_EC_LSB +: 3]; // RULE8
  assign op_mode = st_r.sense_configuration[CFG_MODE_BIT];
  assign shutdown_active = st_r.shutdown_active;

endmodule

// ### sim/irms_host.sv
// Purpose: Bus master model that reaches the sensor registers.
// Assumes: SCL halves of five clocks, well above the slave's minimum.
// Notes: SDA is open drain here; the bench resolves the wire.
`timescale 1ns/10ps
module irms_host
  import irms_pkg::*;
(
  // Clock and resolved data wire.
  input wire logic ref_clk,
  input wire logic sda,
  // Master pins.
  output logic scl,
  output logic sda_low
);
  // Idle bus: both lines released high.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // One bit: data moves only with SCL low, and is sampled late in SCL high.
  task automatic bit_x(input logic b, output logic r);
    wt(2);
    sda_low <= ~b;
    wt(3);
    scl <= 1'b1;
    wt(5);
    r = sda;
    scl <= 1'b0;
  endtask
  // Start or repeated start, or stop.
  task automatic cond(input logic stop);
    wt(2);
    sda_low <= stop;
    wt(3);
    scl <= 1'b1;
    wt(5);
    sda_low <= !stop;
    wt(5);
    scl <= stop;
  endtask
  // Eight bits MSB first, then the acknowledge bit left released.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], rx[i]);
    end
    bit_x(1'b1, ack);
  endtask
  // Write: address, index, data. Read: address, index, restart, address, data, nack.
  task automatic acc(input logic [6:0] a, input logic rd, input logic [7:0] idx,
                     input logic [7:0] d, output logic [7:0] q, output logic ok);
    logic [2:0] k;
    logic nk;
    cond(1'b0);
    xfer({a, DIR_WRITE}, q, k[0]);
    xfer(idx, q, k[1]);
    if (rd) begin
      cond(1'b0);
      xfer({a, DIR_READ}, q, k[2]);
      xfer(8'hff, q, nk);
    end else begin
      xfer(d, q, k[2]);
    end
    cond(1'b1);
    ok = !(|k);
  endtask
endmodule

// ### sim/irms_regs_sva.sv
// Purpose: Port checks for the sensor register block.
// Assumes: One clock; reset asynchronous and active low.
// Notes: The release count follows the block's own parameter.
`timescale 1ns/10ps
module irms_regs_chk
  import irms_pkg::*;
#(
  parameter int unsigned IRQ_HOLD_CYCLES = IRQ_HOLD_CYC
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Watched pins.
  input wire logic scl_in,
  input wire logic hw_shutdown_n,
  input wire logic det_valid,
  input wire logic sda_oe,
  input wire logic irq_n,
  input wire logic emitter_pulse,
  input wire logic [2:0] emitter_current_sel,
  input wire logic op_mode,
  input wire logic shutdown_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  int unsigned low_cnt_r;
  // Low time of irq_n; any detection strobe restarts it, though only a status change restarts the release timer.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_r <= 0;
    end else begin
      low_cnt_r <= (irq_n || det_valid) ? 0 : low_cnt_r + 1;
    end
  end
  a_irq_cause: assert property ($fell(irq_n) |-> $past(det_valid))
    else $error("irq_n fell without a detection strobe");
  a_irq_hw_gate: assert property ($fell(irq_n) |-> $past(hw_shutdown_n))
    else $error("irq_n fell in hardware shutdown");
  a_hw_shdn: assert property (!hw_shutdown_n |-> ##[1:2] shutdown_active)
    else $error("hardware shutdown not reported");
  a_irq_timeout: assert property (!irq_n |-> low_cnt_r < IRQ_HOLD_CYCLES)
    else $error("irq_n held low past the release time");
  a_pulse_shdn: assert property (shutdown_active && $past(shutdown_active) |-> !emitter_pulse)
    else $error("emitter pulse while shut down");
  a_pulse_gap: assert property (emitter_pulse |=> !emitter_pulse [*7])
    else $error("emitter pulses closer than eight cycles");
  a_ack_steady: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("sda drive changed while scl high");
  a_mode_upd: assert property ($changed(op_mode) |-> !scl_in)
    else $error("mode changed outside a bus write");
  a_cur_upd: assert property ($changed(emitter_current_sel) |-> !scl_in)
    else $error("current code changed outside a bus write");
endmodule

bind irms_regs irms_regs_chk #(.IRQ_HOLD_CYCLES(IRQ_HOLD_CYCLES)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl_in), .hw_shutdown_n(hw_shutdown_n),
  .det_valid(det_valid), .sda_oe(sda_oe), .irq_n(irq_n), .emitter_pulse(emitter_pulse),
  .emitter_current_sel(emitter_current_sel), .op_mode(op_mode),
  .shutdown_active(shutdown_active));

// ### sim/testbench.sv
// Purpose: Self-checking bench for the sensor register block.
// Assumes: Host model on the bus; front end codes driven here.
// Notes: Release time shortened to 1000 clocks, longer than a whole status read, so that a
// read and not the timer is what releases irq_n in the row loop.
`timescale 1ns/10ps
module testbench
  import irms_pkg::*;
;
  localparam int unsigned HOLD = 1000;
  typedef struct packed {
    logic [7:0] cfg;
    logic [1:0] prox;
    logic [1:0] mot;
    logic [7:0] stat;
    logic irq;
  } irms_row_t;
  logic ref_clk, rst_n, hw_shutdown_n, det_valid, motion_active, scl, sda_low, ok;
  logic sda_out, sda_oe, irq_n, emitter_pulse, op_mode, shutdown_active;
  logic [1:0] det_prox_code, det_motion_code;
  logic [2:0] emitter_current_sel;
  logic [7:0] q;
  int errors, compares, cyc;
  // Pull-up wire: low when either side pulls.
  wire logic sda = (sda_oe ? sda_out : 1'b1) & !sda_low;
  // Config, proximity and motion codes, expected status, expected interrupt.
  irms_row_t rows [6] = '{'{8'h00, 2'h2, 2'h1, 8'h01, 1'b1}, '{8'h00, 2'h0, 2'h2, 8'h02, 1'b1},
    '{8'h03, 2'h1, 2'h1, 8'h06, 1'b1}, '{8'h05, 2'h2, 2'h1, 8'h0a, 1'b1},
    '{8'h09, 2'h2, 2'h0, 8'h0a, 1'b0}, '{8'h0e, 2'h1, 2'h0, 8'h08, 1'b1}};
  irms_regs #(.IRQ_HOLD_CYCLES(HOLD)) DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .hw_shutdown_n(hw_shutdown_n), .det_valid(det_valid),
    .det_prox_code(det_prox_code), .det_motion_code(det_motion_code),
    .motion_active(motion_active), .irq_n(irq_n), .emitter_pulse(emitter_pulse),
    .emitter_current_sel(emitter_current_sel), .op_mode(op_mode),
    .shutdown_active(shutdown_active));
  irms_host host (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("Compares %0d, errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // One-cycle strobe of new codes; looks one edge after irq_n should react.
  task automatic det(input logic [1:0] p, input logic [1:0] m);
    @(posedge ref_clk);
    det_prox_code <= p;
    det_motion_code <= m;
    det_valid <= 1'b1;
    @(posedge ref_clk);
    det_valid <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    host.acc(SLAVE_ADDR, 1'b0, idx, d, q, ok);
    chk("write ack", ok, 8'h01);
  endtask
  // Pulses in 512 cycles; the first cycles after a change are skipped.
  task automatic duty(input logic [7:0] cfg, input logic act, input logic [7:0] exp);
    int n = 0;
    wr(IDX_SENSE_CONFIGURATION, cfg);
    motion_active <= act;
    repeat (4) @(posedge ref_clk);
    repeat (512) begin
      @(posedge ref_clk);
      n += emitter_pulse;
    end
    chk("pulses", n[7:0], exp);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Hang guard well above the expected run length.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    {rst_n, det_valid, motion_active, det_prox_code, det_motion_code} = '0;
    hw_shutdown_n = 1'b1;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("reset", {irq_n, shutdown_active, op_mode, emitter_current_sel, sda_oe,
                  emitter_pulse}, 8'hc0);
    det(2'h2, 2'h1);
    chk("soft shdn irq", irq_n, 8'h01);
    wr(IDX_SHUTDOWN_CONTROL, 8'h01);
    foreach (rows[i]) begin
      wr(IDX_SENSE_CONFIGURATION, rows[i].cfg);
      chk("mode", op_mode, rows[i].cfg[0]);
      chk("current", emitter_current_sel, rows[i].cfg[3:1]);
      det(rows[i].prox, rows[i].mot);
      chk("irq", irq_n, !rows[i].irq);
      host.acc(SLAVE_ADDR, 1'b1, IDX_MOTION_STATUS, 8'h00, q, ok);
      chk("status", q, rows[i].stat);
      chk("irq clear", irq_n, 8'h01);
    end
    det(2'h0, 2'h1);
    repeat (HOLD - 2) @(posedge ref_clk);
    #1;
    chk("irq held", irq_n, 8'h00);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("irq timeout", irq_n, 8'h01);
    host.acc(7'h2a, 1'b0, IDX_SENSE_CONFIGURATION, 8'h01, q, ok);
    chk("foreign nack", ok, 8'h00);
    wr(IDX_MOTION_STATUS, 8'hff);
    wr(8'h22, 8'hff);
    chk("cfg kept", {op_mode, emitter_current_sel}, 8'h07);
    host.acc(SLAVE_ADDR, 1'b1, IDX_MOTION_STATUS, 8'h00, q, ok);
    chk("status kept", q, 8'h09);
    wr(IDX_SHUTDOWN_CONTROL, 8'h00);
    chk("soft shdn", shutdown_active, 8'h01);
    @(posedge ref_clk);
    hw_shutdown_n <= 1'b0;
    wr(IDX_SHUTDOWN_CONTROL, 8'h01);
    chk("hw shdn", shutdown_active, 8'h01);
    det(2'h0, 2'h2);
    chk("hw shdn irq", irq_n, 8'h01);
    @(posedge ref_clk);
    hw_shutdown_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("resume", {shutdown_active, op_mode, emitter_current_sel}, 8'h07);
    duty(8'h01, 1'b1, 8'h01);
    duty(8'h00, 1'b1, 8'h40);
    duty(8'h00, 1'b0, 8'h01);
    conclude();
  end
endmodule
